// ==== common/ssed_pkg.sv ====
// Package: register map, field positions and state codes of the scan state entry decoder
package ssed_pkg;
   // Register byte offsets on the Wishbone bus
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_DAC_SIX  = 8'h08;
   localparam logic [7:0] REG_DAC_SEV  = 8'h0C;
   localparam logic [7:0] REG_CNT_ONE  = 8'h10;
   localparam logic [7:0] REG_CNT_TWO  = 8'h14;
   localparam logic [7:0] REG_TABLE    = 8'h40;
   localparam int         ADR_W        = 8;
   localparam int         DAT_W        = 32;
   localparam int         SEL_W        = 4;

   // State entry table
   localparam int         NUM_STATES   = 8;
   localparam int         IDX_W        = 3;
   localparam int         ENTRY_W      = 16;
   localparam logic [15:0] ENTRY_RST   = 16'h0000;
   localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
   localparam logic [IDX_W-1:0] IDX_ONE  = 3'h1;

   // Fields of a timing state entry
   localparam int F_REP_HI   = 15;
   localparam int F_REP_LO   = 11;
   localparam int F_SLOW_CLK = 10;
   localparam int F_END      = 9;
   localparam int F_DAC      = 8;
   localparam int F_TEST_SET = 7;
   localparam int F_LATCH    = 6;
   localparam int F_FAST_ON  = 5;
   localparam int F_COMP     = 4;
   localparam int F_EXCITE   = 3;
   localparam int F_UNDAMP   = 2;
   localparam int F_CH_HI    = 1;
   localparam int F_CH_LO    = 0;
   localparam int REP_W      = 5;
   localparam logic [REP_W-1:0] REP_ZERO = 5'h00;
   localparam logic [REP_W-1:0] REP_ONE  = 5'h01;

   // Control register fields
   localparam int C_START     = 0;
   localparam int C_DAC_FORCE = 1;
   localparam int C_CMP_FORCE = 2;
   localparam int C_SAMPLE    = 3;
   localparam int C_TERM      = 4;
   localparam int C_OSC_SEL   = 5;
   localparam int C_Q6_EN     = 6;
   localparam int C_Q7_EN     = 7;
   localparam int C_C1_DN_EN  = 8;
   localparam int C_C1_UP_EN  = 9;
   localparam int C_C2_EN     = 10;
   localparam int C_TCH0_LO   = 12;
   localparam int C_TCH0_HI   = 13;
   localparam int C_TCH1_LO   = 14;
   localparam int C_TCH1_HI   = 15;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] CTRL_MASK = 16'hF7FE;

   // Status register fields
   localparam int S_RUN     = 0;
   localparam int S_IDX_LO  = 4;
   localparam int S_FLAG5   = 8;
   localparam int S_FLAG6   = 9;
   localparam int S_NXT_LO  = 16;

   // Processing machine table entry
   localparam int PSM_W     = 8;
   localparam int NXT_W     = 6;
   localparam int CNT_W     = 16;
   localparam int DAC_W     = 10;
   localparam int CH_W      = 2;
   localparam int NUM_CH    = 4;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [DAC_W-1:0] DAC_RST = 10'h000;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_RUN  = 2'b10
   } ssed_seq_t;
endpackage

// ==== common/ssed_dec_if.sv ====
// Interface between the sequencer top and the table entry decoder
`timescale 1ns/1ps
`default_nettype none
interface ssed_dec_if;
   import ssed_pkg::*;
   logic [PSM_W-1:0] entry;
   logic             q6_en;
   logic             q7_en;
   logic             cnt1_dn_en;
   logic             cnt1_up_en;
   logic             cnt2_en;
   logic [NXT_W-1:0] next_state;
   logic             set_flag5;
   logic             set_flag6;
   logic             cnt1_dec;
   logic             cnt1_inc;
   logic             cnt2_dec;
   logic             advance_now;

   modport dec (
      input  entry, q6_en, q7_en, cnt1_dn_en, cnt1_up_en, cnt2_en,
      output next_state, set_flag5, set_flag6, cnt1_dec, cnt1_inc, cnt2_dec, advance_now
   );
   modport user (
      output entry, q6_en, q7_en, cnt1_dn_en, cnt1_up_en, cnt2_en,
      input  next_state, set_flag5, set_flag6, cnt1_dec, cnt1_inc, cnt2_dec, advance_now
   );
endinterface
`default_nettype wire

// ==== logic/ssed_psm_decode.sv ====
// Combinational decoder of one processing machine table entry byte
`timescale 1ns/1ps
`default_nettype none
module ssed_psm_decode
   import ssed_pkg::*;
(
   ssed_dec_if.dec d
);
   logic q6_eff;
   logic q7_eff;

   // Bit 7 only counts while bit 6 is enabled too
   assign q6_eff        = d.entry[6] & d.q6_en;
   assign q7_eff        = d.entry[7] & d.q6_en & d.q7_en;
   assign d.set_flag6   = d.entry[7];
   assign d.set_flag5   = d.entry[6];
   assign d.advance_now = q7_eff;
   assign d.next_state  = {d.entry[5], d.entry[4], d.entry[3],
                           d.entry[0], q7_eff, q6_eff};
   assign d.cnt1_dec    = d.entry[2] & d.cnt1_dn_en;
   assign d.cnt2_dec    = d.entry[2] & d.cnt2_en;
   assign d.cnt1_inc    = d.entry[1] & d.cnt1_up_en;
endmodule
`default_nettype wire

// ==== logic/ssed_top.sv ====
// Scan timing state entry sequencer, front-end strobe decode and table entry decode
//
// Notes on behaviour
// - End bit set: sequence stops after this state; clear: next entry follows, except that the sequence also stops after the last entry.
// - Entry bit 8 turns the DAC on for the state unless global force-on.
// - Entry bit 7 picks test channel set one and DAC data seven, else zero/six.
// - Entry bit 6 enables the front-end output latches during the state.
// - Entry bit 5 keeps the fast clock running in slow-clocked states.
// - With the core oscillator as fast source, bit 5 forces it running.
// - Entry bit 4 powers the comparator unless global comparator force-on.
// - Bit 3 excites when sample mode 0, termination 1; samples in reverse case.
// - Bit 2 with termination undamps the selected channel; otherwise all damped.
// - Two low entry bits select input channel zero to three.
// - Entry byte bit 7 sets flag six; with both enables advances immediately.
// - Entry byte bit 6 sets flag five and, enabled, joins the next state.
// - Byte bits 5,4,3 give next-state bits 5,4,3; byte bit 0 gives bit 2.
// - Byte bit 2 decrements counter one and two when their enables are set.
// - Byte bit 1 increments counter one when its increment enable is set.
// - An end-of-sequence state lasts exactly one fast clock period.
// - A state lasts repeat count plus one cycles of its selected clock.
// - Bit 7 enable acts only while the bit 6 enable is also set.
`timescale 1ns/1ps
`default_nettype none
module ssed_top
   import ssed_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [ADR_W-1:0]   wb_adr_i,
   input  wire logic [SEL_W-1:0]   wb_sel_i,
   input  wire logic [DAT_W-1:0]   wb_dat_i,
   output logic      [DAT_W-1:0]   wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               aclk_i,
   input  wire logic [PSM_W-1:0]   psm_entry_i,
   input  wire logic               psm_valid_i,
   output logic                    seq_active_o,
   output logic                    seq_end_o,
   output logic                    dac_on_o,
   output logic      [DAC_W-1:0]   dac_data_o,
   output logic                    test_set_o,
   output logic      [CH_W-1:0]    test_channel_o,
   output logic                    latch_en_o,
   output logic                    fast_clk_on_o,
   output logic                    osc_force_on_o,
   output logic                    comp_on_o,
   output logic                    excite_o,
   output logic                    sample_o,
   output logic      [NUM_CH-1:0]  undamp_o,
   output logic      [CH_W-1:0]    channel_o,
   output logic      [NXT_W-1:0]   psm_next_state_o,
   output logic                    psm_step_o
);
   ssed_dec_if dif ();

   logic [ENTRY_W-1:0] table_ff [NUM_STATES];
   logic [15:0]        ctrl_ff;
   logic [DAC_W-1:0]   dac_six_ff;
   logic [DAC_W-1:0]   dac_sev_ff;
   logic [CNT_W-1:0]   cnt1_ff;
   logic [CNT_W-1:0]   cnt2_ff;
   logic               flag5_ff;
   logic               flag6_ff;
   logic [NXT_W-1:0]   nxt_state_ff;
   logic               ack_ff;
   logic [DAT_W-1:0]   rdat_ff;
   logic               aclk_s1_ff;
   logic               aclk_s2_ff;
   logic               aclk_s3_ff;
   logic               aclk_lvl_ff;
   ssed_seq_t          seq_ff;
   logic [IDX_W-1:0]   idx_ff;
   logic [REP_W-1:0]   rep_ff;
   logic               start_ff;

   logic               wr_stb;
   logic               rd_stb;
   logic [DAT_W-1:0]   lane_mask;
   logic [DAT_W-1:0]   nxt_rdat;
   logic               aclk_rise;
   logic [ENTRY_W-1:0] cur;
   logic               running;
   logic               tick;
   logic               state_done;
   logic               seq_stop;
   logic               wr_status;

   // Bus request taken once; ack_ff blocks a second take during the ack cycle
   assign wr_stb    = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff;
   assign rd_stb    = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
   assign wr_status = wr_stb & (wb_adr_i == REG_STATUS);

   genvar gb;
   generate
      for (gb = 0; gb < SEL_W; gb++) begin : g_lane
         assign lane_mask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
      end
   endgenerate

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [DAT_W-1:0] dat,
                                          input logic [DAT_W-1:0] msk);
      merge16 = (old_v & ~msk[15:0]) | (dat[15:0] & msk[15:0]);
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_ff <= 32'h0000_0000;
      end else if (rd_stb) begin
         rdat_ff <= nxt_rdat;
      end
   end

   // Read mux; unmapped addresses read zero and still get an ack
   always_comb begin
      nxt_rdat = 32'h0000_0000;
      if (wb_adr_i >= REG_TABLE &&
          wb_adr_i < REG_TABLE + ADR_W'(4 * NUM_STATES) && wb_adr_i[1:0] == 2'h0) begin
         nxt_rdat[ENTRY_W-1:0] = table_ff[wb_adr_i[IDX_W+1:2]];
      end else begin
         case (wb_adr_i)
            REG_CTRL:    nxt_rdat[15:0] = ctrl_ff;
            REG_STATUS: begin
               nxt_rdat[S_RUN]                  = running;
               nxt_rdat[S_IDX_LO +: IDX_W]      = idx_ff;
               nxt_rdat[S_FLAG5]                = flag5_ff;
               nxt_rdat[S_FLAG6]                = flag6_ff;
               nxt_rdat[S_NXT_LO +: NXT_W]      = nxt_state_ff;
            end
            REG_DAC_SIX: nxt_rdat[DAC_W-1:0] = dac_six_ff;
            REG_DAC_SEV: nxt_rdat[DAC_W-1:0] = dac_sev_ff;
            REG_CNT_ONE: nxt_rdat[CNT_W-1:0] = cnt1_ff;
            REG_CNT_TWO: nxt_rdat[CNT_W-1:0] = cnt2_ff;
            default:     nxt_rdat = 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // Entry table, one flip-flop word per state
   genvar gs;
   generate
      for (gs = 0; gs < NUM_STATES; gs++) begin : g_tab
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               table_ff[gs] <= ENTRY_RST;
            end else if (wr_stb && wb_adr_i == REG_TABLE + ADR_W'(4 * gs)) begin
               table_ff[gs] <= merge16(table_ff[gs], wb_dat_i, lane_mask);
            end
         end
      end
   endgenerate

   // Start bit is not stored; it only launches a sequence
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff  <= CTRL_RST;
         start_ff <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         if (wr_stb && wb_adr_i == REG_CTRL) begin
            ctrl_ff  <= merge16(ctrl_ff, wb_dat_i, lane_mask) & CTRL_MASK;
            start_ff <= wb_dat_i[C_START] & wb_sel_i[0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dac_six_ff <= DAC_RST;
         dac_sev_ff <= DAC_RST;
      end else if (wr_stb) begin
         if (wb_adr_i == REG_DAC_SIX) begin
            dac_six_ff <= DAC_W'(merge16(16'(dac_six_ff), wb_dat_i, lane_mask));
         end
         if (wb_adr_i == REG_DAC_SEV) begin
            dac_sev_ff <= DAC_W'(merge16(16'(dac_sev_ff), wb_dat_i, lane_mask));
         end
      end
   end

   // Slow clock: three stages, a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aclk_s1_ff  <= 1'b0;
         aclk_s2_ff  <= 1'b0;
         aclk_s3_ff  <= 1'b0;
         aclk_lvl_ff <= 1'b0;
      end else begin
         aclk_s1_ff <= aclk_i;
         aclk_s2_ff <= aclk_s1_ff;
         aclk_s3_ff <= aclk_s2_ff;
         if (aclk_s2_ff == aclk_s3_ff) begin
            aclk_lvl_ff <= aclk_s3_ff;
         end
      end
   end

   assign aclk_rise = (aclk_s2_ff == aclk_s3_ff) & aclk_s3_ff & ~aclk_lvl_ff;

   // Sequencer: clk_i is the fast clock period
   assign running    = (seq_ff == SEQ_RUN);
   assign cur        = table_ff[idx_ff];
   assign tick       = cur[F_SLOW_CLK] ? aclk_rise : 1'b1;
   assign state_done = tick & (rep_ff == cur[F_REP_HI:F_REP_LO]);
   // End state always ends on the first fast edge, whatever its clock and count
   assign seq_stop   = running & (cur[F_END] | (state_done & idx_ff == IDX_LAST));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_ff <= SEQ_IDLE;
         idx_ff <= '0;
         rep_ff <= REP_ZERO;
      end else begin
         case (seq_ff)
            SEQ_IDLE: begin
               if (start_ff) begin
                  seq_ff <= SEQ_RUN;
                  idx_ff <= '0;
                  rep_ff <= REP_ZERO;
               end
            end
            SEQ_RUN: begin
               if (seq_stop) begin
                  seq_ff <= SEQ_IDLE;
                  rep_ff <= REP_ZERO;
               end else if (state_done) begin
                  idx_ff <= idx_ff + IDX_ONE;
                  rep_ff <= REP_ZERO;
               end else if (tick) begin
                  rep_ff <= rep_ff + REP_ONE;
               end
            end
            default: begin
               seq_ff <= SEQ_IDLE;
            end
         endcase
      end
   end

   // Front-end strobes, registered from the current entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_active_o   <= 1'b0;
         seq_end_o      <= 1'b0;
         dac_on_o       <= 1'b0;
         dac_data_o     <= DAC_RST;
         test_set_o     <= 1'b0;
         test_channel_o <= '0;
         latch_en_o     <= 1'b0;
         fast_clk_on_o  <= 1'b0;
         osc_force_on_o <= 1'b0;
         comp_on_o      <= 1'b0;
         excite_o       <= 1'b0;
         sample_o       <= 1'b0;
         channel_o      <= '0;
      end else begin
         seq_active_o   <= running;
         seq_end_o      <= seq_stop;
         dac_on_o       <= ctrl_ff[C_DAC_FORCE] | (running & cur[F_DAC]);
         test_set_o     <= cur[F_TEST_SET];
         dac_data_o     <= cur[F_TEST_SET] ? dac_sev_ff : dac_six_ff;
         test_channel_o <= cur[F_TEST_SET] ? ctrl_ff[C_TCH1_HI:C_TCH1_LO]
                                           : ctrl_ff[C_TCH0_HI:C_TCH0_LO];
         latch_en_o     <= running & cur[F_LATCH];
         // Slow-clocked states need bit 5 to keep the fast source alive
         fast_clk_on_o  <= running & (~cur[F_SLOW_CLK] | cur[F_FAST_ON]);
         osc_force_on_o <= running & ctrl_ff[C_OSC_SEL]
                           & (~cur[F_SLOW_CLK] | cur[F_FAST_ON]);
         comp_on_o      <= ctrl_ff[C_CMP_FORCE] | (running & cur[F_COMP]);
         excite_o       <= running & cur[F_EXCITE] & ~ctrl_ff[C_SAMPLE]
                           & ctrl_ff[C_TERM];
         sample_o       <= running & cur[F_EXCITE] & ctrl_ff[C_SAMPLE]
                           & ~ctrl_ff[C_TERM];
         channel_o      <= cur[F_CH_HI:F_CH_LO];
      end
   end

   // Undamping is not tied to the excite bit: software keeps them consistent
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               undamp_o[gc] <= 1'b0;
            end else begin
               undamp_o[gc] <= running & cur[F_UNDAMP] & ctrl_ff[C_TERM]
                               & (cur[F_CH_HI:F_CH_LO] == CH_W'(gc));
            end
         end
      end
   endgenerate

   // Table entry decode
   assign dif.entry      = psm_entry_i;
   assign dif.q6_en      = ctrl_ff[C_Q6_EN];
   assign dif.q7_en      = ctrl_ff[C_Q7_EN];
   assign dif.cnt1_dn_en = ctrl_ff[C_C1_DN_EN];
   assign dif.cnt1_up_en = ctrl_ff[C_C1_UP_EN];
   assign dif.cnt2_en    = ctrl_ff[C_C2_EN];

   ssed_psm_decode u_dec (
      .d (dif.dec)
   );

   // Step waits for the sequencer end unless the immediate-advance case applies
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nxt_state_ff <= '0;
         psm_step_o   <= 1'b0;
      end else begin
         psm_step_o <= psm_valid_i & (dif.advance_now | seq_stop);
         if (psm_valid_i) begin
            nxt_state_ff <= dif.next_state;
         end
      end
   end

   assign psm_next_state_o = nxt_state_ff;

   // Sticky flags: a new set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag5_ff <= 1'b0;
         flag6_ff <= 1'b0;
      end else begin
         flag5_ff <= (psm_valid_i & dif.set_flag5)
                     | (flag5_ff & ~(wr_status & wb_sel_i[1] & wb_dat_i[S_FLAG5]));
         flag6_ff <= (psm_valid_i & dif.set_flag6)
                     | (flag6_ff & ~(wr_status & wb_sel_i[1] & wb_dat_i[S_FLAG6]));
      end
   end

   // Increment and decrement together leave counter one unchanged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt1_ff <= CNT_RST;
         cnt2_ff <= CNT_RST;
      end else if (psm_valid_i) begin
         if (dif.cnt1_inc & ~dif.cnt1_dec) begin
            cnt1_ff <= cnt1_ff + CNT_ONE;
         end else if (dif.cnt1_dec & ~dif.cnt1_inc) begin
            cnt1_ff <= cnt1_ff - CNT_ONE;
         end
         if (dif.cnt2_dec) begin
            cnt2_ff <= cnt2_ff - CNT_ONE;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/ssed_afe_model.sv ====
// Front-end partner: free-running auxiliary clock and LC tank watch
`timescale 1ns/1ps
`default_nettype none
module ssed_afe_model #(
   parameter int HALF_NS = 97
) (
   input  wire logic       clk_i,
   input  wire logic       excite_i,
   input  wire logic [3:0] undamp_i,
   output logic            aclk_o,
   output logic            lc_fault_o
);
   logic fault_ff = 1'b0;

   assign lc_fault_o = fault_ff;

   // Odd offset keeps the aux clock unrelated in phase to clk_i
   initial begin
      aclk_o = 1'b0;
      #13;
      forever #(HALF_NS) aclk_o = ~aclk_o;
   end
   // Driving a damped tank wastes the pulse, so it is latched as a fault
   always @(posedge clk_i) begin
      if (excite_i && undamp_i == 4'b0000) fault_ff <= 1'b1;
   end
endmodule
`default_nettype wire

// ==== tb/ssed_assertions.sv ====
// Concurrent checks on the scan state entry decoder ports
`timescale 1ns/1ps
`default_nettype none
module ssed_assertions
   import ssed_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_ack_o,
   input wire logic [PSM_W-1:0]  psm_entry_i,
   input wire logic              psm_valid_i,
   input wire logic              seq_active_o,
   input wire logic              seq_end_o,
   input wire logic              fast_clk_on_o,
   input wire logic              osc_force_on_o,
   input wire logic              excite_o,
   input wire logic              sample_o,
   input wire logic [NUM_CH-1:0] undamp_o,
   input wire logic [CH_W-1:0]   channel_o,
   input wire logic [NXT_W-1:0]  psm_next_state_o,
   input wire logic              psm_step_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged next cycle");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held too long");
   next_state_a: assert property (psm_valid_i |=>
      psm_next_state_o[5:2] == {$past(psm_entry_i[5:3]), $past(psm_entry_i[0])})
      else $error("next state bits not taken from entry");
   gate_high_a: assert property (psm_valid_i && !psm_entry_i[7] |=> !psm_next_state_o[1])
      else $error("clear bit seven reached next state");
   gate_low_a: assert property (psm_valid_i && !psm_entry_i[6] |=> !psm_next_state_o[0])
      else $error("clear bit six reached next state");
   step_cause_a: assert property (psm_step_o |-> $past(psm_valid_i))
      else $error("step without an entry");
   undamp_sel_a: assert property (undamp_o != 4'b0000 |-> undamp_o == 4'b0001 << channel_o)
      else $error("undamped channel differs from selected one");
   ex_samp_a: assert property (!(excite_o && sample_o))
      else $error("excite and sample together");
   osc_force_a: assert property (osc_force_on_o |-> fast_clk_on_o)
      else $error("oscillator forced with fast clock off");
   end_pulse_a: assert property ($rose(seq_end_o) |=> !seq_end_o)
      else $error("end pulse longer than one cycle");
   end_run_a: assert property (seq_end_o |-> seq_active_o)
      else $error("end pulse without a running sequence");
endmodule
bind ssed_top ssed_assertions chk (.*);
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the scan state entry decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ssed_pkg::*;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, pv = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [DAT_W-1:0] wdat = '0, rdat, rq;
   logic [PSM_W-1:0] pe = '0;
   logic [SEL_W-1:0] sel = 4'hF;
   logic             ack, act, sq_end, dac_on, tset, latch, fast, osc, comp, ex, samp;
   logic             step, aclk, fault;
   logic [3:0]       undamp;
   logic [1:0]       chan, tch, fl;
   logic [9:0]       dac;
   logic [5:0]       nxt;
   logic [23:0]      snap;
   logic [15:0]      c1, c2;
   int               bad_count = 0;
   int               comparisons = 0;
   int               act_n, lat_n, dac_n, end_n;

   always #2.5 clk_i = ~clk_i;

   ssed_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .aclk_i(aclk), .psm_entry_i(pe), .psm_valid_i(pv), .seq_active_o(act),
      .seq_end_o(sq_end), .dac_on_o(dac_on), .dac_data_o(dac), .test_set_o(tset),
      .test_channel_o(tch), .latch_en_o(latch), .fast_clk_on_o(fast), .osc_force_on_o(osc),
      .comp_on_o(comp), .excite_o(ex), .sample_o(samp), .undamp_o(undamp), .channel_o(chan),
      .psm_next_state_o(nxt), .psm_step_o(step));
   ssed_afe_model afe (.clk_i(clk_i), .excite_i(ex), .undamp_i(undamp), .aclk_o(aclk),
      .lc_fault_o(fault));

   always @(posedge clk_i) begin
      if (act) act_n++;
      if (latch) lat_n++;
      if (sq_end) end_n++;
      if (dac_on) begin
         dac_n++;
         snap = {fast, osc, comp, ex, samp, undamp, chan, tset, tch, dac};
      end
   end

   task automatic conclude;
      $display("Counts: %0d compared, %0d bad", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic hang;
      bad_count++;
      $display("BAD wait expected done seen timeout");
      conclude();
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rq = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) hang();
      @(posedge clk_i);
   endtask

   task automatic run_seq(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] c);
      int n;
      wb(1'b1, REG_TABLE, {16'h0000, e0});
      wb(1'b1, REG_TABLE + 8'h04, {16'h0000, e1});
      act_n = 0;
      lat_n = 0;
      dac_n = 0;
      end_n = 0;
      wb(1'b1, REG_CTRL, {16'h0000, c | 16'h0001});
      n = 0;
      while (end_n == 0 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (end_n == 0) hang();
      repeat (2) @(posedge clk_i);
   endtask

   task automatic t_regs;
      logic [7:0] ra [8] = '{REG_CTRL, REG_STATUS, REG_DAC_SIX, REG_DAC_SEV, REG_CNT_ONE,
         REG_CNT_TWO, REG_TABLE, 8'h80};
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, ra[i], '0);
         chk("reset value", '0, rq);
      end
      wb(1'b1, 8'h80, 32'hFFFF_FFFF);
      wb(1'b0, 8'h80, '0);
      chk("unmapped", '0, rq);
      wb(1'b1, REG_DAC_SIX, 32'hFFFF_FFFF);
      wb(1'b0, REG_DAC_SIX, '0);
      chk("dac six", 32'h0000_03FF, rq);
      wb(1'b1, REG_CTRL, 32'h0000_FFFE);
      wb(1'b0, REG_CTRL, '0);
      chk("control", 32'h0000_F7FE, rq);
      chk("forced dac", 1, dac_on);
      chk("forced comparator", 1, comp);
      wb(1'b1, REG_CTRL, '0);
      chk("released dac", 0, dac_on);
      $display("t_regs done");
   endtask

   task automatic t_seq;
      run_seq(16'h095E, 16'h1E40, 16'h0010);
      chk("dac cycles", 2, dac_n);
      chk("latch cycles", 3, lat_n);
      chk("active cycles", 3, act_n);
      chk("end pulses", 1, end_n);
      chk("excite", {5'b10110, 4'b0100, 2'd2, 3'd0, 10'h3FF}, snap);
      run_seq(16'h095E, 16'h1E40, 16'h0008);
      chk("sample", {5'b10101, 4'b0000, 2'd2, 3'd0, 10'h3FF}, snap);
      wb(1'b1, REG_DAC_SIX, 32'h0000_0155);
      wb(1'b1, REG_DAC_SEV, 32'h0000_02AA);
      run_seq(16'h01C0, 16'h0200, 16'hD010);
      chk("test set one", {5'b10000, 4'b0000, 2'd0, 3'b111, 10'h2AA}, snap);
      run_seq(16'h0140, 16'h0200, 16'hD010);
      chk("test set zero", {5'b10000, 4'b0000, 2'd0, 3'b001, 10'h155}, snap);
      run_seq(16'h0560, 16'h0200, 16'h0020);
      chk("fast kept", {5'b11000, 9'd0, 10'h155}, snap);
      run_seq(16'h0540, 16'h0200, 16'h0020);
      chk("fast off", {5'b00000, 9'd0, 10'h155}, snap);
      run_seq(16'h0040, 16'h0040, 16'h0000);
      chk("last entry stop", 8, act_n);
      chk("latch pair", 2, lat_n);
      $display("t_seq done");
   endtask

   task automatic t_psm;
      logic [12:0] cs [7] = '{13'h1FFF, 13'h02C0, 13'h01C9, 13'h0404, 13'h0802, 13'h0026,
         13'h1C02};
      logic [4:0] en;
      logic [7:0] b;
      logic g6, g7;
      c1 = '0;
      c2 = '0;
      fl = '0;
      for (int i = 0; i < 7; i++) begin
         en = cs[i][12:8];
         b = cs[i][7:0];
         wb(1'b1, REG_CTRL, {21'h0, en, 6'h00});
         pe <= b;
         pv <= 1'b1;
         @(posedge clk_i);
         pv <= 1'b0;
         @(posedge clk_i);
         g6 = en[0] & b[6];
         g7 = en[0] & en[1] & b[7];
         chk("next state", {b[5:3], b[0], g7, g6}, nxt);
         chk("step", g7, step);
         if (b[2] & en[2] & !(b[1] & en[3])) c1--;
         else if (b[1] & en[3] & !(b[2] & en[2])) c1++;
         if (b[2] & en[4]) c2--;
         fl = fl | b[7:6];
         wb(1'b0, REG_CNT_ONE, '0);
         chk("counter one", c1, rq);
         wb(1'b0, REG_CNT_TWO, '0);
         chk("counter two", c2, rq);
         wb(1'b0, REG_STATUS, '0);
         chk("flags", fl, rq[9:8]);
      end
      wb(1'b1, REG_STATUS, 32'h0000_0300);
      wb(1'b0, REG_STATUS, '0);
      chk("flags cleared", 0, rq[9:8]);
      $display("t_psm done");
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_seq();
      t_psm();
      chk("damped excitation", 0, fault);
      conclude();
   end
endmodule
`default_nettype wire
